// >>> logic/host_if_pkg.sv
package host_if_pkg;

  // Frame geometry
  localparam int unsigned FRAME_LONG     = 32;
  localparam int unsigned FRAME_SHORT    = 24;
  localparam int unsigned CHECK_BITS     = 8;
  localparam logic [7:0]  CHECK_POLY     = 8'h07;
  localparam logic [5:0]  CNT_MAX        = 6'h3F;
  localparam logic [5:0]  LEN_LONG       = 6'h20;
  localparam logic [5:0]  LEN_SHORT      = 6'h18;

  // Frame field positions inside the 24-bit command
  localparam int unsigned RW_POS         = 23;
  localparam int unsigned ADDR_MSB       = 22;
  localparam int unsigned ADDR_LSB       = 16;
  localparam int unsigned STATUS_ERR_POS = 6;

  // Timing of the sclk and serial limits
  localparam real         SCLK_MAX_MHZ   = 12.5;
  localparam real         SYS_CLK_MHZ    = 40.0;

  // Register offsets
  localparam logic [6:0]  ADDR_CONFIG    = 7'h02;
  localparam logic [6:0]  ADDR_GPIO_DATA = 7'h1C;
  localparam logic [6:0]  ADDR_GPIO_CFG  = 7'h1B;
  localparam logic [6:0]  ADDR_BREAK     = 7'h2F;

  // Configuration register fields
  localparam int unsigned CFG_ASYNC_DIS  = 0;
  localparam int unsigned CFG_RDBK_DIS   = 1;
  localparam int unsigned CFG_FALL_SEL   = 2;
  localparam int unsigned CFG_CLR_EN     = 3;
  localparam int unsigned CFG_IRQ_EN     = 4;
  localparam int unsigned CFG_CHECK_EN   = 5;
  localparam int unsigned CFG_CLOCK_OUTPUT_ENABLE_EN    = 6;
  localparam logic [15:0] CONFIG_RESET   = 16'h0022;
  localparam logic [15:0] CONFIG_MASK    = 16'h007F;

  // Pin-sharing register fields
  localparam int unsigned GPIO_EN_LSB    = 0;
  localparam int unsigned GPIO_ODE_LSB   = 8;
  localparam logic [15:0] GPIO_CFG_RESET = 16'h7F00;
  localparam logic [6:0]  GPIO_DATA_RST  = 7'h7F;
  localparam int unsigned BREAK_POS      = 0;

  // Pin indexes
  localparam int unsigned PIN_CS         = 6;
  localparam int unsigned PIN_SDI        = 5;
  localparam int unsigned PIN_SDO        = 4;
  localparam int unsigned PIN_RX         = 3;
  localparam int unsigned PIN_TX         = 2;
  localparam int unsigned PIN_G1         = 1;
  localparam int unsigned PIN_CLOCK_OUTPUT_ENABLE       = 0;
  localparam logic [6:0]  PIN_LEVEL_RST  = 7'h7F;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EVAL = 3'b010,
    ST_EXEC = 3'b100
  } commit_state_t;

  typedef struct packed {
    logic [6:0] data_in;
    logic [6:0] data_out;
    logic [6:0] drive_en;
  } pin_bus_t;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [15:0] data;
  } reg_access_t;

  typedef struct packed {
    logic        started_seen;
    logic [5:0]  cnt;
    logic [31:0] shift;
    logic        out_bit;
  } link_state_t;

  typedef struct packed {
    commit_state_t state;
    logic [6:0]    pin_s1;
    logic [6:0]    pin_s2;
    logic [6:0]    pin_s3;
    logic [6:0]    pin_level;
    logic          cs_prev;
    logic [15:0]   config_reg;
    logic [15:0]   gpio_cfg;
    logic [6:0]    gpio_data;
    logic          break_mode;
    logic          f_rw;
    logic [6:0]    f_addr;
    logic [15:0]   f_data;
    logic          f_err;
    logic [31:0]   resp;
    logic          sdo_link;
    logic [6:0]    pin_out;
    logic [6:0]    pin_oe;
    logic          clear_out;
    logic          async_rx;
    reg_access_t   ext;
  } sys_state_t;

endpackage : host_if_pkg

// >>> logic/host_if_select.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Clocked serial frames carry an 8-bit check byte, on by default, switchable off.
// - After reset both links work; once one is chosen the other stays locked out.
// - Clocked serial reaches every register except the break-mode access register.
// - Async-link-disable bit set to 1 commits to clocked serial; async access stops.
// - Clocked serial mode with irq pin enable turns async transmit pin into irq.
// - Readback output stays high-impedance until readback disable is cleared to 0.
// - Every reset clears break-mode register; async link starts at 9600 baud.
// - Break-mode bit written over async link blocks clocked serial, opens full map.
// - Break mode: irq enable makes data output the irq; clear enable makes input clear.
// - Seven pins serve as general I/O once the interface mode is known.
// - Chip select, data in and data out become I/O by break mode and pin enables.
// - Receive, pin 1, transmit and clock-out pin I/O conditions plus per-pin enable.
// - I/O pin is input only when open-drain select and data bit both 1.
// - Otherwise it drives its data bit, push-pull or pseudo open-drain.
// - Pin data reads always return pin levels, never the written values.
// - Clock modes 1 and 2 supported, continuous or gated serial clock up to 12.5 MHz.
// - First bit on first falling edge after select falls, last before select rises.
// - Checked frame is 32 bits: rw, 7-bit address, 16-bit data, 8-bit check.
// - With checking disabled the frame is 24 bits with no check byte.
// - Select rising before a full frame discards it, registers untouched.
// - Extra falling edges keep only the most recent full frame of bits.
// - Commit on select rising; select high blocks clock, input and output.
// - Rw 1 reads, 0 writes; read data returns in the following frame.
// - Check byte uses x^8+x^2+x+1 over 24 bits; nonzero remainder blocks execution.
// - Input bits latched on falling edges; right-justified last bits form the frame.
module host_if_select
  import host_if_pkg::*;
(
  // System clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // Serial clock from the host
  input  wire logic        i_sclk,
  // Shared pins
  input  wire logic [6:0]  i_pin_in,
  output logic [6:0]       o_pin_out,
  output logic [6:0]       o_pin_oe,
  // Async character engine side
  input  wire logic        i_async_wr,
  input  wire logic [6:0]  i_async_addr,
  input  wire logic [15:0] i_async_data,
  input  wire logic        i_async_tx,
  output logic             o_async_rx,
  output logic             o_async_en,
  // Other device functions
  input  wire logic        i_irq,
  input  wire logic        i_clk_out,
  input  wire logic [15:0] i_ext_rdata,
  output logic             o_ext_wr,
  output logic [6:0]       o_ext_addr,
  output logic [15:0]      o_ext_data,
  output logic             o_clear,
  output logic             o_break_mode,
  output logic             o_check_err
);

  function automatic logic [7:0] crc8(input logic [31:0] bits, input int unsigned n);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      if (i < int'(n)) begin
        fb = c[7] ^ bits[i];
        c  = {c[6:0], 1'b0} ^ (fb ? CHECK_POLY : 8'h00);
      end
    end
    return c;
  endfunction : crc8

  function automatic sys_state_t write_reg(input sys_state_t s, input logic [6:0] a,
                                           input logic [15:0] d, input logic from_async);
    sys_state_t r;
    r = s;
    r.ext = '0;
    if (a == ADDR_CONFIG) begin
      r.config_reg = d & CONFIG_MASK;
      if (s.break_mode) begin
        r.config_reg[CFG_ASYNC_DIS] = 1'b0;
      end
      if (s.config_reg[CFG_ASYNC_DIS]) begin
        r.config_reg[CFG_ASYNC_DIS] = 1'b1;
      end
    end else if (a == ADDR_GPIO_CFG) begin
      r.gpio_cfg = d;
    end else if (a == ADDR_GPIO_DATA) begin
      r.gpio_data = d[6:0];
    end else if (a == ADDR_BREAK) begin
      if (from_async && !s.config_reg[CFG_ASYNC_DIS]) begin
        r.break_mode = s.break_mode | d[BREAK_POS];
      end
    end else begin
      r.ext.wr   = 1'b1;
      r.ext.addr = a;
      r.ext.data = d;
    end
    return r;
  endfunction : write_reg

  // Link domain: started flag cleared while select is high
  logic        started;
  link_state_t lk;
  link_state_t next_lk;
  sys_state_t  st;
  sys_state_t  next_st;

  always_ff @(negedge i_sclk or posedge i_pin_in[PIN_CS]) begin
    if (i_pin_in[PIN_CS]) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  always_comb begin
    logic [5:0] len;
    logic [5:0] cnt_new;
    logic [31:0] sh_new;
    len     = st.config_reg[CFG_CHECK_EN] ? LEN_LONG : LEN_SHORT;
    next_lk = lk;
    cnt_new = 6'h00;
    sh_new  = {lk.shift[30:0], i_pin_in[PIN_SDI]};
    if (!i_pin_in[PIN_CS]) begin
      if (!started) begin
        cnt_new = 6'h01;
      end else if (lk.cnt != CNT_MAX) begin
        cnt_new = lk.cnt + 6'h01;
      end else begin
        cnt_new = lk.cnt;
      end
      next_lk.cnt          = cnt_new;
      next_lk.shift        = sh_new;
      next_lk.started_seen = 1'b1;
      if (cnt_new < len) begin
        next_lk.out_bit = st.resp[5'(31 - cnt_new)];
      end else begin
        next_lk.out_bit = sh_new[5'(len - 6'h01)];
      end
    end
  end

  always_ff @(negedge i_sclk) begin
    lk <= next_lk;
  end

  // System domain
  always_comb begin
    logic [5:0]  len;
    logic [23:0] cmd;
    logic [15:0] rdata;
    logic        check_en;
    logic        async_dis;
    logic [6:0]  avail;
    logic [6:0]  gpio_sel;
    logic [6:0]  en;
    logic [6:0]  open_drain_select;
    next_st = st;
    next_st.ext = '0;
    check_en  = st.config_reg[CFG_CHECK_EN];
    async_dis = st.config_reg[CFG_ASYNC_DIS];
    len   = check_en ? LEN_LONG : LEN_SHORT;
    cmd   = check_en ? lk.shift[31:8] : lk.shift[23:0];
    rdata = 16'h0000;

    // Three-stage pin synchroniser, level rises when stages two and three are both high, falls when they differ
    next_st.pin_s1    = i_pin_in;
    next_st.pin_s2    = st.pin_s1;
    next_st.pin_s3    = st.pin_s2;
    next_st.pin_level = (st.pin_s2 & st.pin_s3) | (st.pin_level & ~(st.pin_s2 ^ st.pin_s3));
    next_st.cs_prev   = st.pin_level[PIN_CS];

    case (st.state)
      ST_IDLE: begin
        if (st.pin_level[PIN_CS] && !st.cs_prev) begin
          next_st.state = ST_EVAL;
        end
      end
      ST_EVAL: begin
        next_st.state = ST_IDLE;
        if (lk.started_seen && (lk.cnt >= len) && !st.break_mode) begin
          next_st.f_rw   = cmd[RW_POS];
          next_st.f_addr = cmd[ADDR_MSB:ADDR_LSB];
          next_st.f_data = cmd[15:0];
          next_st.f_err  = check_en && (crc8(lk.shift, FRAME_LONG) != 8'h00);
          next_st.ext.addr = cmd[ADDR_MSB:ADDR_LSB];
          next_st.state  = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_st.state = ST_IDLE;
        if (!st.f_err) begin
          if (st.f_rw) begin
            if (st.f_addr == ADDR_CONFIG) begin
              rdata = st.config_reg;
            end else if (st.f_addr == ADDR_GPIO_CFG) begin
              rdata = st.gpio_cfg;
            end else if (st.f_addr == ADDR_GPIO_DATA) begin
              rdata = {9'h000, st.pin_level};
            end else if (st.f_addr == ADDR_BREAK) begin
              rdata = 16'h0000;
            end else begin
              rdata = i_ext_rdata;
            end
          end else begin
            next_st = write_reg(next_st, st.f_addr, st.f_data, 1'b0);
            next_st.state = ST_IDLE;
          end
        end
        next_st.resp[31]    = st.f_rw;
        next_st.resp[30:24] = {st.f_err, 6'h00};
        next_st.resp[23:8]  = rdata;
        next_st.resp[7:0]   = crc8({8'h00, st.f_rw, st.f_err, 6'h00, rdata}, FRAME_SHORT);
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase

    // Async engine writes reach the whole map until the link is disabled
    if (i_async_wr && !async_dis) begin
      next_st = write_reg(next_st, i_async_addr, i_async_data, 1'b1);
    end

    // Pin availability per interface mode
    avail[PIN_CS]   = st.break_mode;
    avail[PIN_SDI]  = st.break_mode && !st.config_reg[CFG_CLR_EN];
    avail[PIN_SDO]  = st.break_mode && !st.config_reg[CFG_IRQ_EN];
    avail[PIN_RX]   = async_dis;
    avail[PIN_TX]   = async_dis && !st.config_reg[CFG_IRQ_EN];
    avail[PIN_G1]   = async_dis;
    avail[PIN_CLOCK_OUTPUT_ENABLE] = !st.config_reg[CFG_CLOCK_OUTPUT_ENABLE_EN] && (st.break_mode || async_dis);
    en       = st.gpio_cfg[GPIO_EN_LSB +: 7];
    open_drain_select      = st.gpio_cfg[GPIO_ODE_LSB +: 7];
    gpio_sel = avail & en;

    for (int i = 0; i < 7; i++) begin
      if (gpio_sel[i]) begin
        next_st.pin_out[i] = st.gpio_data[i];
        next_st.pin_oe[i]  = open_drain_select[i] ? ~st.gpio_data[i] : 1'b1;
      end else begin
        next_st.pin_out[i] = 1'b0;
        next_st.pin_oe[i]  = 1'b0;
      end
    end
    if (!gpio_sel[PIN_SDO] && st.break_mode && st.config_reg[CFG_IRQ_EN]) begin
      next_st.pin_out[PIN_SDO] = i_irq;
      next_st.pin_oe[PIN_SDO]  = 1'b1;
    end
    if (!gpio_sel[PIN_TX]) begin
      if (async_dis && st.config_reg[CFG_IRQ_EN]) begin
        next_st.pin_out[PIN_TX] = i_irq;
        next_st.pin_oe[PIN_TX]  = 1'b1;
      end else if (!async_dis) begin
        next_st.pin_out[PIN_TX] = i_async_tx;
        next_st.pin_oe[PIN_TX]  = 1'b1;
      end
    end
    if (st.config_reg[CFG_CLOCK_OUTPUT_ENABLE_EN]) begin
      next_st.pin_out[PIN_CLOCK_OUTPUT_ENABLE] = i_clk_out;
      next_st.pin_oe[PIN_CLOCK_OUTPUT_ENABLE]  = 1'b1;
    end
    next_st.sdo_link  = !st.break_mode;
    next_st.clear_out = st.break_mode && st.config_reg[CFG_CLR_EN] && st.pin_level[PIN_SDI];
    next_st.async_rx  = st.pin_level[PIN_RX];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st            <= '0;
      st.state      <= ST_IDLE;
      st.pin_s1     <= PIN_LEVEL_RST;
      st.pin_s2     <= PIN_LEVEL_RST;
      st.pin_s3     <= PIN_LEVEL_RST;
      st.pin_level  <= PIN_LEVEL_RST;
      st.cs_prev    <= 1'b1;
      st.config_reg <= CONFIG_RESET;
      st.gpio_cfg   <= GPIO_CFG_RESET;
      st.gpio_data  <= GPIO_DATA_RST;
      st.break_mode <= 1'b0;
      st.sdo_link   <= 1'b1;
      st.async_rx   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Data output: link bit while select is low and readback is on
  always_comb begin
    o_pin_out = st.pin_out;
    o_pin_oe  = st.pin_oe;
    if (st.sdo_link) begin
      o_pin_out[PIN_SDO] = started ? lk.out_bit : st.resp[31];
      o_pin_oe[PIN_SDO]  = !i_pin_in[PIN_CS] && !st.config_reg[CFG_RDBK_DIS];
    end
  end

  assign o_async_rx   = st.async_rx;
  assign o_async_en   = !st.config_reg[CFG_ASYNC_DIS];
  assign o_ext_wr     = st.ext.wr;
  assign o_ext_addr   = st.ext.addr;
  assign o_ext_data   = st.ext.data;
  assign o_clear      = st.clear_out;
  assign o_break_mode = st.break_mode;
  assign o_check_err  = st.f_err;

endmodule : host_if_select

// >>> tb/host_if_select_props.sv
`timescale 1ns/100ps
module host_if_select_props
  import host_if_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  // Watched ports
  input  wire logic [6:0] i_pin_in,
  input  wire logic [6:0] o_pin_oe,
  input  wire logic       i_async_wr,
  input  wire logic       o_async_en,
  input  wire logic       o_ext_wr,
  input  wire logic [6:0] o_ext_addr,
  input  wire logic       o_clear,
  input  wire logic       o_break_mode
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  property p_reset_state;
    i_srst |=> !o_break_mode && o_async_en && o_pin_oe == 7'h00;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");
  property p_async_sticky;
    disable iff (i_srst) !o_async_en |=> !o_async_en;
  endproperty
  a_async_sticky: assert property (p_async_sticky) else $error("async back on");
  property p_brk_sticky;
    disable iff (i_srst) o_break_mode |=> o_break_mode;
  endproperty
  a_brk_sticky: assert property (p_brk_sticky) else $error("break mode left");
  property p_brk_async;
    disable iff (i_srst) o_break_mode |-> o_async_en;
  endproperty
  a_brk_async: assert property (p_brk_async) else $error("break without async");
  property p_sdo_idle;
    disable iff (i_srst) i_pin_in[PIN_CS] && !o_break_mode |-> !o_pin_oe[PIN_SDO];
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("data out driven");
  property p_serial_pins;
    disable iff (i_srst) !o_break_mode |-> o_pin_oe[6:5] == 2'b00;
  endproperty
  a_serial_pins: assert property (p_serial_pins) else $error("select pin driven");
  property p_clear_break;
    disable iff (i_srst) o_clear |-> o_break_mode;
  endproperty
  a_clear_break: assert property (p_clear_break) else $error("clear outside break");
  property p_async_refused;
    disable iff (i_srst) !o_async_en && i_async_wr |=> !o_ext_wr;
  endproperty
  a_async_refused: assert property (p_async_refused) else $error("async write taken");
  property p_ext_local;
    disable iff (i_srst) o_ext_wr |-> o_ext_addr != ADDR_BREAK && o_ext_addr != ADDR_CONFIG;
  endproperty
  a_ext_local: assert property (p_ext_local) else $error("local address sent out");
  property p_brk_src;
    disable iff (i_srst) o_ext_wr && $past(o_break_mode) |-> $past(i_async_wr);
  endproperty
  a_brk_src: assert property (p_brk_src) else $error("serial write in break");
endmodule : host_if_select_props

bind host_if_select host_if_select_props i_host_if_select_props (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_pin_in(i_pin_in), .o_pin_oe(o_pin_oe),
  .i_async_wr(i_async_wr), .o_async_en(o_async_en), .o_ext_wr(o_ext_wr),
  .o_ext_addr(o_ext_addr), .o_clear(o_clear), .o_break_mode(o_break_mode)
);

// >>> tb/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
  // Serial pins toward the device
  output logic      o_sclk = 1'b0,
  output logic      o_cs_n = 1'b1,
  output logic      o_sdi  = 1'b0,
  // Data out pin level and enable
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  // Clock stands still between frames; idle level picks mode 1 or 2
  task automatic xfer(input logic [33:0] w, input int n, input logic m2,
                      output logic [31:0] r, output logic seen);
    r = '0;
    seen = 1'b0;
    o_sclk = m2;
    #62.5;
    o_cs_n = 1'b0;
    #62.5;
    for (int k = n - 1; k >= 0; k--) begin
      o_sclk = 1'b1;
      o_sdi = w[k];
      #62.5;
      r = {r[30:0], i_sdo};
      seen |= i_sdo_oe;
      o_sclk = 1'b0;
      #62.5;
    end
    o_sclk = m2;
    #62.5;
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #250;
  endtask : xfer
endmodule : spi_host_model

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import host_if_pkg::*;
`define CHK(g, e) chk(32'(g), 32'(e))
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic        sclk, cs_n, sdi, seen, mode2, awr_en, async_tx, irq, clk_out;
  logic        async_rx, async_en, ext_wr, clr, brk, cerr;
  logic [6:0]  pin_out, pin_oe, pin_lvl, ext_lvl, async_addr, ext_addr;
  logic [15:0] async_data, ext_rdata, ext_data, lfsr, d;
  logic [31:0] resp;
  logic [22:0] last_wr;
  int          err_count = 0;
  int          n_tests   = 0;
  int          wr_cnt    = 0;
  int          n0;
  always #12.5 clk_sys = ~clk_sys;
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & {cs_n, sdi, ext_lvl[4:0]});
  always @(posedge clk_sys) begin
    if (ext_wr === 1'b1) begin
      wr_cnt++;
      last_wr = {ext_addr, ext_data};
    end
  end
  host_if_select i_host_if_select (
    .i_clk_sys(clk_sys), .i_srst(srst), .i_sclk(sclk), .i_pin_in(pin_lvl),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_async_wr(awr_en), .i_async_addr(async_addr),
    .i_async_data(async_data), .i_async_tx(async_tx), .o_async_rx(async_rx),
    .o_async_en(async_en), .i_irq(irq), .i_clk_out(clk_out), .i_ext_rdata(ext_rdata),
    .o_ext_wr(ext_wr), .o_ext_addr(ext_addr), .o_ext_data(ext_data), .o_clear(clr),
    .o_break_mode(brk), .o_check_err(cerr)
  );
  spi_host_model i_spi_host_model (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(pin_lvl[4]), .i_sdo_oe(pin_oe[4])
  );
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
  endfunction : nx
  function automatic logic [31:0] fr(input logic rw, input logic [6:0] a, input logic [15:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 23; k >= 0; k--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ {rw, a, v}[k]) ? CHECK_POLY : 8'h00);
    end
    return {rw, a, v, c};
  endfunction : fr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  task automatic send(input logic [33:0] w, input int n);
    n0 = wr_cnt;
    i_spi_host_model.xfer(w, n, mode2, resp, seen);
  endtask : send
  task automatic stim();
    @(negedge clk_sys);
    lfsr = nx(lfsr);
    {irq, async_tx, clk_out} = lfsr[2:0];
    ext_rdata = lfsr;
    ext_lvl = lfsr[15:9];
    d = lfsr;
  endtask : stim
  task automatic awr(input logic [6:0] a, input logic [15:0] v);
    @(negedge clk_sys);
    {awr_en, async_addr, async_data} = {1'b1, a, v};
    @(negedge clk_sys);
    awr_en = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : awr
  task automatic do_reset();
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask : do_reset
  initial begin
    #500us;
    err_count++;
    results();
  end
  initial begin
    {awr_en, async_tx, irq, clk_out, mode2, async_addr, async_data, ext_rdata, ext_lvl} = '0;
    lfsr = 16'h0060;
    do_reset();
    `CHK({async_en, brk}, 2'b10);
    for (int i = 0; i < 6; i++) begin
      stim();
      mode2 = i[0];
      send({2'b00, fr(1'b0, 7'h10, d)}, 32);
      `CHK(last_wr, {7'h10, d});
      `CHK(seen, 1'b0);
    end
    send({2'b00, fr(1'b0, 7'h11, d) ^ 32'h1}, 32);
    `CHK({wr_cnt - n0, cerr}, 1);
    send({2'b00, fr(1'b0, 7'h11, d)} >> 1, 31);
    `CHK(wr_cnt - n0, 0);
    send({2'b11, fr(1'b0, 7'h12, d)}, 34);
    `CHK(last_wr, {7'h12, d});
    send({2'b00, fr(1'b0, ADDR_CONFIG, 16'h0020)}, 32);
    send({2'b00, fr(1'b1, 7'h15, 16'h0000)}, 32);
    send({2'b00, fr(1'b1, ADDR_GPIO_DATA, 16'h0000)}, 32);
    `CHK(resp, fr(1'b1, 7'h00, d));
    `CHK(seen, 1'b1);
    send({2'b00, fr(1'b1, ADDR_BREAK, 16'h0000)}, 32);
    `CHK(resp[11:8] & 4'hB, pin_lvl[3:0] & 4'hB);
    `CHK(async_rx, pin_lvl[3]);
    send({2'b00, fr(1'b0, ADDR_CONFIG, 16'h0000)}, 32);
    `CHK(resp[23:8], 16'h0000);
    send(34'({1'b0, 7'h13, d}), 24);
    `CHK(last_wr, {7'h13, d});
    send(34'({1'b0, ADDR_CONFIG, 16'h0011}), 24);
    `CHK(async_en, 1'b0);
    stim();
    repeat (3) @(negedge clk_sys);
    `CHK({pin_oe[2], pin_out[2]}, {1'b1, irq});
    n0 = wr_cnt;
    awr(7'h14, d);
    awr(ADDR_BREAK, 16'h0001);
    `CHK({wr_cnt - n0, brk}, 0);
    do_reset();
    `CHK({async_en, brk}, 2'b10);
    awr(ADDR_BREAK, 16'h0001);
    `CHK(brk, 1'b1);
    send({2'b00, fr(1'b0, 7'h16, d)}, 32);
    `CHK(wr_cnt - n0, 0);
    awr(7'h17, d);
    `CHK(last_wr, {7'h17, d});
    awr(ADDR_GPIO_CFG, 16'h007F);
    awr(ADDR_GPIO_DATA, d);
    `CHK({pin_oe & 7'h71, pin_out & 7'h71}, {7'h71, d[6:0] & 7'h71});
    awr(ADDR_GPIO_CFG, 16'h7F7F);
    `CHK(pin_oe & 7'h71, ~d[6:0] & 7'h71);
    `CHK(pin_out & pin_oe & 7'h71, 7'h00);
    awr(ADDR_CONFIG, 16'h0018);
    repeat (4) @(negedge clk_sys);
    `CHK({pin_oe[4], pin_out[4], clr}, {1'b1, irq, pin_lvl[5]});
    results();
  end
endmodule : tb_top
